// *** dv/dca_ctrl_model.sv ***
// link-side controller model: differential clock, clock enable, command strobes and address
`timescale 1ns/1ns
module dca_ctrl_model
    import dca_pkg::*;
(
    input  wire logic              i_core_clk,
    input  wire logic              i_run,
    output logic                   o_ck,
    output logic                   o_ck_n,
    output logic                   o_cke,
    output logic      [3:0]        o_cmd,
    output logic      [BANK_W-1:0] o_ba,
    output logic      [ROW_W-1:0]  o_addr
);
    logic [2:0] ph_reg = 3'h0;
    ////////////////////////////////////////
    // clock starts low so the first crossing seen is a real one; 16 core cycles a period
    initial begin
        o_ck = 1'h0;
        o_cke = 1'h1;
        o_cmd = 4'hf;
        o_ba = 3'h0;
        o_addr = 13'h0000;
    end
    assign o_ck_n = ~o_ck;
    always @(negedge i_core_clk) begin
        if (i_run) begin
            ph_reg <= ph_reg + 3'h1;
            if (ph_reg == 3'h7) o_ck <= ~o_ck;
        end
    end
    // pins stand a full period, centred on the rising crossing, then deselect
    task automatic drive(input logic [3:0] c, input logic [BANK_W-1:0] b, input logic [ROW_W-1:0] a,
                         input logic e);
        @(negedge o_ck);
        o_cmd <= c;
        o_ba <= b;
        o_addr <= a;
        o_cke <= e;
        @(negedge o_ck);
        o_cmd <= 4'hf;
        o_ba <= ~b;
        o_addr <= ~a; // show a changed value after the crossing
    endtask
endmodule

// *** dv/dca_top_asserts.sv ***
// concurrent checks on the ports of the command/address interface
`timescale 1ns/1ns
module dca_top_asserts
    import dca_pkg::*;
(
    input wire logic              i_core_clk,
    input wire logic              i_srst,
    input wire logic              i_cs_n,
    input wire logic              i_ras_n,
    input wire logic              i_cas_n,
    input wire logic              i_we_n,
    input wire logic [BANK_W-1:0] i_ba,
    input wire logic [ROW_W-1:0]  i_addr,
    input wire logic              o_cmd_valid,
    input wire dca_kind_t         o_cmd_kind,
    input wire logic [BANK_W-1:0] o_cmd_bank,
    input wire logic [ROW_W-1:0]  o_cmd_row,
    input wire logic              o_cmd_all_banks,
    input wire dca_pwr_t          o_power_state,
    input wire logic [DQ_W-1:0]   o_dq,
    input wire logic              o_burst_len8,
    input wire logic              o_burst_interleave
);
    ////////////////////////////////////////
    // pins lead the pulse by three core edges: two sync flops, one register
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_srst);
    chk_act_decode: assert property (o_cmd_valid && o_cmd_kind == KIND_ACT |->
        $past({i_cs_n, i_ras_n, i_cas_n, i_we_n}, 3) == CMD_ACT) else $error("activate without its code");
    chk_act_fields: assert property (o_cmd_valid && o_cmd_kind == KIND_ACT |->
        o_cmd_bank == $past(i_ba, 3) && o_cmd_row == $past(i_addr, 3)) else $error("activate bank or row wrong");
    chk_pre_scope: assert property (o_cmd_valid && o_cmd_kind == KIND_PRE |->
        o_cmd_all_banks == $past(i_addr[AP_BIT], 3)) else $error("precharge scope wrong");
    chk_mode_opcode: assert property (o_cmd_valid && o_cmd_kind == KIND_MRS |->
        o_cmd_row == $past(i_addr, 3)) else $error("mode op-code wrong");
    chk_lowpwr_quiet: assert property (o_power_state != PWR_ACTIVE && $past(o_power_state) != PWR_ACTIVE
        |-> !o_cmd_valid) else $error("command decoded in low power");
    chk_dq_frozen: assert property (o_power_state == PWR_SUSPEND && $past(o_power_state) == PWR_SUSPEND
        |-> $stable(o_dq)) else $error("read data moved while suspended");
    chk_burst_type: assert property (o_cmd_valid && o_cmd_kind == KIND_MRS && o_cmd_bank == MR0_SEL
        |-> ##[0:2] o_burst_interleave == o_cmd_row[BT_BIT]) else $error("burst order not programmed");
    chk_burst_len: assert property (o_cmd_valid && o_cmd_kind == KIND_MRS && o_cmd_bank == MR0_SEL
        |-> ##[0:2] o_burst_len8 == (o_cmd_row[1:0] != BL_FIXED4)) else $error("burst length not programmed");
endmodule

// *** dv/dca_top_bench.sv ***
// self-checking bench for the command/address interface
`timescale 1ns/1ns
bind dca_top dca_top_asserts u_chk (.*);
module dca_top_bench
    import dca_pkg::*;
;
    typedef struct packed {
        logic [3:0] c; logic [BANK_W-1:0] b; logic [ROW_W-1:0] a; dca_kind_t k; logic all; logic [BANKS-1:0] open;
    } dca_row_t;
    typedef struct packed {
        logic [3:0] c; logic [ROW_W-1:0] a; logic e; dca_pwr_t p; logic [BANKS-1:0] open;
    } dca_pw_t;
    localparam dca_row_t ROWS [7] = '{'{CMD_MRS, 3'h0, 13'h0008, KIND_MRS, 1'h0, 8'h00},
        '{CMD_MRS, 3'h1, 13'h0000, KIND_MRS, 1'h0, 8'h00}, '{CMD_ACT, 3'h2, 13'h1fff, KIND_ACT, 1'h0, 8'h04},
        '{CMD_ACT, 3'h7, 13'h0123, KIND_ACT, 1'h0, 8'h84}, '{CMD_PRE, 3'h2, 13'h0000, KIND_PRE, 1'h0, 8'h80},
        '{CMD_PRE, 3'h5, 13'h0400, KIND_PRE, 1'h1, 8'h00}, '{CMD_REF, 3'h0, 13'h0000, KIND_REF, 1'h1, 8'h00}};
    localparam dca_pw_t PW [8] = '{'{4'hf, 13'h0, 1'h0, PWR_SUSPEND, 8'h02}, '{CMD_ACT, 13'h0, 1'h0, PWR_SUSPEND, 8'h02},
        '{4'hf, 13'h0, 1'h1, PWR_ACTIVE, 8'h02}, '{CMD_PRE, 13'h0400, 1'h1, PWR_ACTIVE, 8'h00},
        '{4'hf, 13'h0, 1'h0, PWR_PDOWN, 8'h00}, '{4'hf, 13'h0, 1'h1, PWR_ACTIVE, 8'h00},
        '{CMD_REF, 13'h0, 1'h0, PWR_SREF, 8'h00}, '{4'hf, 13'h0, 1'h1, PWR_ACTIVE, 8'h00}};
    logic i_core_clk = 1'h0, i_srst = 1'h1, run = 1'h0, i_rd_valid = 1'h0;
    logic [DQ_W-1:0] i_rd_word = 16'h0000, o_dq;
    logic i_ck, i_ck_n, i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n, o_rd_ready, o_cmd_valid, o_cmd_all_banks;
    logic o_col_valid, o_col_write, o_col_auto_close_flag, o_col_burst_shorten_select, o_clk_suspended;
    logic o_burst_len8, o_burst_interleave, o_dq_oe;
    logic [3:0] cmd;
    logic [BANK_W-1:0] i_ba, o_cmd_bank, o_col_bank;
    logic [ROW_W-1:0] i_addr, o_cmd_row, o_col_row;
    logic [COL_W-1:0] o_col_col;
    logic [BANKS-1:0] o_bank_open;
    logic [CL_W-1:0] o_read_latency_setting, o_posted_command_delay;
    logic [2:0] o_beat_col;
    dca_kind_t o_cmd_kind;
    dca_pwr_t o_power_state;
    int mismatches = 0, comparisons = 0;
    ////////////////////////////////////////
    // design, far-side controller and clock
    dca_top DUT (.*);
    dca_ctrl_model u_ctl (.i_core_clk, .i_run(run), .o_ck(i_ck), .o_ck_n(i_ck_n), .o_cke(i_cke), .o_cmd(cmd),
        .o_ba(i_ba), .o_addr(i_addr));
    assign {i_cs_n, i_ras_n, i_cas_n, i_we_n} = cmd;
    always #5 i_core_clk = ~i_core_clk;
    ////////////////////////////////////////
    task automatic summarize();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    // bounded wait for a level, sampled at the falling edge
    task automatic await(ref logic s);
        int n;
        for (n = 0; n < 200 && s !== 1'h1; n++) @(negedge i_core_clk);
        if (n == 200) begin
            mismatches++;
            summarize();
        end
    endtask
    // valid stays up; a full buffer holds it off, so no word goes twice
    task automatic push(input logic [15:0] w);
        await(o_rd_ready);
        i_rd_word <= w;
        i_rd_valid <= 1'h1;
        @(negedge i_core_clk);
    endtask
    ////////////////////////////////////////
    // reset, command table, read burst, power table, posted delay
    initial begin
        repeat (10) @(negedge i_core_clk);
        check("len8", 1, o_burst_len8);
        check("pwr", PWR_ACTIVE, o_power_state);
        i_srst <= 1'h0;
        repeat (3) @(negedge i_core_clk);
        run <= 1'h1;
        foreach (ROWS[i]) begin
            fork
                u_ctl.drive(ROWS[i].c, ROWS[i].b, ROWS[i].a, 1'h1);
                await(o_cmd_valid);
            join
            check("kind", ROWS[i].k, o_cmd_kind);
            check("bank", ROWS[i].b, o_cmd_bank);
            check("row", ROWS[i].a, o_cmd_row);
            check("all", ROWS[i].all, o_cmd_all_banks);
            check("open", ROWS[i].open, o_bank_open);
        end
        check("cl", 4, o_read_latency_setting);
        check("inter", 1, o_burst_interleave);
        for (int w = 0; w < 4; w++) push(16'ha000 + w);
        check("full", 0, o_rd_ready);
        fork u_ctl.drive(CMD_ACT, 3'h1, 13'h0055, 1'h1); await(o_cmd_valid); join
        fork u_ctl.drive(CMD_RD, 3'h1, 13'h1005, 1'h1); await(o_col_valid); join
        check("col", 5, o_col_col);
        check("colrow", 13'h0055, o_col_row);
        check("write", 0, o_col_write);
        fork
            begin
                for (int w = 4; w < 8; w++) push(16'ha000 + w);
                i_rd_valid <= 1'h0;
            end
            begin
                await(o_dq_oe);
                for (int b = 0; b < 8; b++) begin
                    check("dq", 16'ha000 + b, o_dq);
                    check("beat", b ^ 5, o_beat_col);
                    repeat (8) @(negedge i_core_clk);
                end
            end
        join
        check("drain", 1, o_rd_ready);
        foreach (PW[i]) begin
            u_ctl.drive(PW[i].c, 3'h3, PW[i].a, PW[i].e);
            check("pwr", PW[i].p, o_power_state);
            check("open", PW[i].open, o_bank_open);
        end
        for (int m = 1; m < 3; m++) begin
            u_ctl.drive(CMD_MRS, 3'h1, 13'(m << 3), 1'h1);
            check("al", 4 - m, o_posted_command_delay);
        end
        summarize();
    end
endmodule

// *** hdl/dca_fifo.sv ***
// small first-in first-out buffer with valid/ready on both sides
`timescale 1ns/1ns
module dca_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_srst,
    input  wire logic [WIDTH-1:0] i_in_data,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    output logic      [WIDTH-1:0] o_out_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [CW-1:0]               cnt;
    } dca_fifo_state_t;

    dca_fifo_state_t s_reg;
    dca_fifo_state_t s_next;
    logic            push;
    logic            pop;

    // flags straight from the occupancy count
    assign o_in_ready  = (s_reg.cnt != CW'(DEPTH));
    assign o_out_valid = (s_reg.cnt != '0);
    assign o_out_data  = s_reg.mem[s_reg.rp];
    assign push        = i_in_valid & o_in_ready;
    assign pop         = o_out_valid & i_out_ready;

    // pointers wrap explicitly so any depth works, not only powers of two
    always_comb begin
        s_next = s_reg;
        if (push) begin
            s_next.mem[s_reg.wp] = i_in_data;
            s_next.wp = (s_reg.wp == AW'(DEPTH - 1)) ? '0 : s_reg.wp + AW'(1);
        end
        if (pop) begin
            s_next.rp = (s_reg.rp == AW'(DEPTH - 1)) ? '0 : s_reg.rp + AW'(1);
        end
        if (push && !pop) begin
            s_next.cnt = s_reg.cnt + CW'(1);
        end else if (pop && !push) begin
            s_next.cnt = s_reg.cnt - CW'(1);
        end
    end

    // state register
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

endmodule

// *** hdl/dca_top.sv ***
// command, clock-enable and address interface of a double-data-rate memory device
`timescale 1ns/1ns

// Overview of operation
// - every pin is captured at the rising clock crossing
// - read data leaves on both clock crossings
// - clock enable low freezes output and burst from next cycle
// - clock enable low with banks idle enters power-down or self refresh
// - bank inputs pick the bank of each bank command
// - activate takes all address inputs as the row
// - read or write takes ten low address bits as column
// - mode register set loads the address as op-code
// - mode register picks burst length four or eight
// - burst columns run sequential or interleaved
// - posted delay zero, latency less one or two, defers column commands
// - eight independent banks of sixteen-bit words
// - auto-close bit closes bank after access; on precharge, all banks
// - in on-the-fly mode, burst-shorten bit low chops the burst, high keeps it; fixed modes ignore it
// - chip select high masks every command
// - select and strobes decode activate, precharge, read, write
module dca_top
    import dca_pkg::*;
(
    input  wire logic              i_core_clk,
    input  wire logic              i_srst,
    input  wire logic              i_ck,
    input  wire logic              i_ck_n,
    input  wire logic              i_cke,
    input  wire logic              i_cs_n,
    input  wire logic              i_ras_n,
    input  wire logic              i_cas_n,
    input  wire logic              i_we_n,
    input  wire logic [BANK_W-1:0] i_ba,
    input  wire logic [ROW_W-1:0]  i_addr,
    input  wire logic [DQ_W-1:0]   i_rd_word,
    input  wire logic              i_rd_valid,
    output logic                   o_rd_ready,
    output logic                   o_cmd_valid,
    output dca_kind_t              o_cmd_kind,
    output logic      [BANK_W-1:0] o_cmd_bank,
    output logic      [ROW_W-1:0]  o_cmd_row,
    output logic                   o_cmd_all_banks,
    output logic                   o_col_valid,
    output logic                   o_col_write,
    output logic      [BANK_W-1:0] o_col_bank,
    output logic      [ROW_W-1:0]  o_col_row,
    output logic      [COL_W-1:0]  o_col_col,
    output logic                   o_col_auto_close_flag,
    output logic                   o_col_burst_shorten_select,
    output logic      [BANKS-1:0]  o_bank_open,
    output dca_pwr_t               o_power_state,
    output logic                   o_clk_suspended,
    output logic                   o_burst_len8,
    output logic                   o_burst_interleave,
    output logic      [CL_W-1:0]   o_read_latency_setting,
    output logic      [CL_W-1:0]   o_posted_command_delay,
    output logic      [DQ_W-1:0]   o_dq,
    output logic                   o_dq_oe,
    output logic      [2:0]        o_beat_col
);

    ////////////////////////////////////////
    // state
    typedef struct packed {
        dca_pins_t                   pin_s1;
        dca_pins_t                   pin_s2;
        logic                        diff_prev;
        dca_pwr_t                    pwr;
        logic [1:0]                  bl_mode;
        logic                        interleave;
        logic [CL_W-1:0]             cl;
        logic [1:0]                  al_sel;
        logic [BANKS-1:0]            open;
        logic [BANKS-1:0][ROW_W-1:0] rows;
        logic                        post_busy;
        logic [CL_W-1:0]             post_cnt;
        logic                        post_write;
        logic [BANK_W-1:0]           post_bank;
        logic [COL_W-1:0]            post_col;
        logic                        post_ap;
        logic                        post_chop;
        logic                        lat_busy;
        logic [LAT_W-1:0]            lat_cnt;
        logic                        rd_chop;
        logic [2:0]                  rd_start;
        logic                        burst_act;
        logic [2:0]                  beat;
        logic [2:0]                  last;
        logic                        cmd_valid;
        dca_kind_t                   cmd_kind;
        logic [BANK_W-1:0]           cmd_bank;
        logic [ROW_W-1:0]            cmd_row;
        logic                        cmd_all;
        logic                        col_valid;
        logic                        col_write;
        logic [BANK_W-1:0]           col_bank;
        logic [ROW_W-1:0]            col_row;
        logic [COL_W-1:0]            col_col;
        logic                        col_ap;
        logic                        col_chop;
        logic [DQ_W-1:0]             dq;
        logic                        dq_oe;
        logic [2:0]                  beat_col;
    } dca_state_t;

    dca_state_t       s_reg;
    dca_state_t       s_next;
    logic [DQ_W-1:0]  fifo_data;
    logic             fifo_valid;
    logic             fifo_pop;

    ////////////////////////////////////////
    // helpers
    // posted delay in clock cycles from the code and the read latency
    function automatic logic [CL_W-1:0] al_cycles(input logic [1:0] sel, input logic [CL_W-1:0] cl);
        case (sel)
            AL_CLM1: al_cycles = cl - AL_OFF1;
            AL_CLM2: al_cycles = cl - AL_OFF2;
            default: al_cycles = '0;
        endcase
    endfunction

    // chop decision: the address bit only counts in on-the-fly mode
    function automatic logic chop_of(input logic [1:0] mode, input logic a12);
        chop_of = (mode == BL_OTF) ? ~a12 : (mode == BL_FIXED4);
    endfunction

    // column order inside a burst; sequential wraps within each group of four
    function automatic logic [2:0] order_col(input logic [2:0] start, input logic [2:0] beat,
                                             input logic inter);
        order_col = inter ? (start ^ beat) : {start[2] ^ beat[2], 2'(start[1:0] + beat[1:0])};
    endfunction

    ////////////////////////////////////////
    // read data buffer between the array and the pins
    dca_fifo #(
        .WIDTH (DQ_W),
        .DEPTH (FIFO_DEPTH)
    ) u_rd_fifo (
        .i_core_clk  (i_core_clk),
        .i_srst      (i_srst),
        .i_in_data   (i_rd_word),
        .i_in_valid  (i_rd_valid),
        .o_in_ready  (o_rd_ready),
        .o_out_data  (fifo_data),
        .o_out_valid (fifo_valid),
        .i_out_ready (fifo_pop)
    );

    ////////////////////////////////////////
    // next state
    always_comb begin
        dca_pins_t        p;
        logic             diff;
        logic             rise;
        logic             fall;
        logic             run;
        logic [3:0]       cmd4;
        logic [CL_W-1:0]  al;
        logic             idle;
        p    = s_reg.pin_s2;
        diff = p.ck & ~p.ck_n;
        rise = diff & ~s_reg.diff_prev;
        fall = ~diff & s_reg.diff_prev;
        run  = (s_reg.pwr == PWR_ACTIVE);
        cmd4 = {p.cs_n, p.ras_n, p.cas_n, p.we_n};
        al   = al_cycles(s_reg.al_sel, s_reg.cl);
        idle = (s_reg.open == '0) && !s_reg.post_busy && !s_reg.lat_busy && !s_reg.burst_act;
        s_next           = s_reg;
        s_next.pin_s1    = {i_ck, i_ck_n, i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n, i_ba, i_addr};
        s_next.pin_s2    = s_reg.pin_s1;
        s_next.diff_prev = diff;
        s_next.cmd_valid = 1'b0;
        s_next.col_valid = 1'b0;
        fifo_pop         = 1'b0;
        if (rise) begin
            // clock enable sampled at the rising crossing; effect starts next cycle
            if (p.cke) begin
                s_next.pwr = PWR_ACTIVE;
            end else if (run && idle) begin
                s_next.pwr = (cmd4 == CMD_REF) ? PWR_SREF : PWR_PDOWN;
            end else if (run) begin
                s_next.pwr = PWR_SUSPEND;
            end
        end
        if (rise && run) begin
            // posted command countdown
            if (s_reg.post_busy && s_reg.post_cnt != '0) begin
                s_next.post_cnt = s_reg.post_cnt - CL_W'(1);
            end
            // read latency countdown opens the burst
            if (s_reg.lat_busy) begin
                if (s_reg.lat_cnt == LAT_W'(1)) begin
                    s_next.lat_busy  = 1'b0;
                    s_next.burst_act = 1'b1;
                    s_next.beat      = '0;
                    s_next.last      = s_reg.rd_chop ? LAST_BEAT4 : LAST_BEAT8;
                end else begin
                    s_next.lat_cnt = s_reg.lat_cnt - LAT_W'(1);
                end
            end
            // command decode; a deselected device matches no code
            if (p.cke || cmd4 != CMD_REF) begin
                case (cmd4)
                    CMD_ACT: begin
                        s_next.open[p.ba] = 1'b1;
                        s_next.rows[p.ba] = p.addr;
                        s_next.cmd_valid  = 1'b1;
                        s_next.cmd_kind   = KIND_ACT;
                    end
                    CMD_PRE: begin
                        if (p.addr[AP_BIT]) begin
                            s_next.open = '0;
                        end else begin
                            s_next.open[p.ba] = 1'b0;
                        end
                        s_next.cmd_valid = 1'b1;
                        s_next.cmd_kind  = KIND_PRE;
                    end
                    CMD_RD, CMD_WR: begin
                        // one posted slot: a later column command replaces a waiting one
                        s_next.post_busy  = 1'b1;
                        s_next.post_cnt   = al;
                        s_next.post_write = (cmd4 == CMD_WR);
                        s_next.post_bank  = p.ba;
                        s_next.post_col   = p.addr[COL_W-1:0];
                        s_next.post_ap    = p.addr[AP_BIT];
                        s_next.post_chop  = chop_of(s_reg.bl_mode, p.addr[BC_BIT]);
                        if (cmd4 == CMD_RD) begin
                            s_next.lat_busy = 1'b1;
                            s_next.lat_cnt  = LAT_W'(al) + LAT_W'(s_reg.cl);
                            s_next.rd_chop  = s_next.post_chop;
                            s_next.rd_start = p.addr[2:0];
                        end
                    end
                    CMD_MRS: begin
                        if (p.ba == MR0_SEL) begin
                            s_next.bl_mode    = p.addr[BL_LSB +: 2];
                            s_next.interleave = p.addr[BT_BIT];
                            s_next.cl         = CL_BASE + CL_W'(p.addr[CL_LSB +: 3])
                                              + (p.addr[CL_HI_BIT] ? CL_HI_STEP : '0);
                        end else if (p.ba == MR1_SEL) begin
                            s_next.al_sel = p.addr[AL_LSB +: 2];
                        end
                        s_next.cmd_valid = 1'b1;
                        s_next.cmd_kind  = KIND_MRS;
                    end
                    CMD_REF: begin
                        s_next.cmd_valid = 1'b1;
                        s_next.cmd_kind  = KIND_REF;
                    end
                    default: ;
                endcase
                if (s_next.cmd_valid) begin
                    s_next.cmd_bank = p.ba;
                    s_next.cmd_row  = p.addr;
                    s_next.cmd_all  = (cmd4 == CMD_REF) || (cmd4 == CMD_PRE && p.addr[AP_BIT]);
                end
            end
            // posted column command reaches the array once its delay is spent
            if (s_next.post_busy && s_next.post_cnt == '0) begin
                s_next.post_busy = 1'b0;
                s_next.col_valid = 1'b1;
                s_next.col_write = s_next.post_write;
                s_next.col_bank  = s_next.post_bank;
                s_next.col_row   = s_reg.rows[s_next.post_bank];
                s_next.col_col   = s_next.post_col;
                s_next.col_ap    = s_next.post_ap;
                s_next.col_chop  = s_next.post_chop;
                if (s_next.post_ap) begin
                    s_next.open[s_next.post_bank] = 1'b0;
                end
            end
        end
        // read beats on every crossing; a dry buffer holds the beat rather than send junk
        if ((rise || fall) && run) begin
            if (s_reg.burst_act) begin
                if (fifo_valid) begin
                    fifo_pop        = 1'b1;
                    s_next.dq       = fifo_data;
                    s_next.dq_oe    = 1'b1;
                    s_next.beat_col = order_col(s_reg.rd_start, s_reg.beat, s_reg.interleave);
                    s_next.beat     = s_reg.beat + 3'h1;
                    if (s_reg.beat == s_reg.last) begin
                        s_next.burst_act = 1'b0;
                    end
                end
            end else begin
                s_next.dq_oe = 1'b0;
            end
        end
    end

    ////////////////////////////////////////
    // state register
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            s_reg    <= '0;
            s_reg.cl <= CL_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////
    // outputs
    assign o_cmd_valid                = s_reg.cmd_valid;
    assign o_cmd_kind                 = s_reg.cmd_kind;
    assign o_cmd_bank                 = s_reg.cmd_bank;
    assign o_cmd_row                  = s_reg.cmd_row;
    assign o_cmd_all_banks            = s_reg.cmd_all;
    assign o_col_valid                = s_reg.col_valid;
    assign o_col_write                = s_reg.col_write;
    assign o_col_bank                 = s_reg.col_bank;
    assign o_col_row                  = s_reg.col_row;
    assign o_col_col                  = s_reg.col_col;
    assign o_col_auto_close_flag      = s_reg.col_ap;
    assign o_col_burst_shorten_select = s_reg.col_chop;
    assign o_bank_open                = s_reg.open;
    assign o_power_state              = s_reg.pwr;
    assign o_clk_suspended            = (s_reg.pwr == PWR_SUSPEND);
    assign o_burst_len8               = (s_reg.bl_mode != BL_FIXED4);
    assign o_burst_interleave         = s_reg.interleave;
    assign o_read_latency_setting     = s_reg.cl;
    assign o_posted_command_delay     = al_cycles(s_reg.al_sel, s_reg.cl);
    assign o_dq                       = s_reg.dq;
    assign o_dq_oe                    = s_reg.dq_oe;
    assign o_beat_col                 = s_reg.beat_col;

endmodule

// *** include/dca_pkg.sv ***
// constants, pin bundle and enumerations of the command/address interface
package dca_pkg;

    // array organisation
    localparam int BANK_W     = 3;
    localparam int ROW_W      = 13;
    localparam int COL_W      = 10;
    localparam int DQ_W       = 16;
    localparam int BANKS      = 8;
    localparam int FIFO_DEPTH = 4;
    localparam int LAT_W      = 6;
    localparam int CL_W       = 5;

    // command codes {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_MRS = 4'h0;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_WR  = 4'h4;
    localparam logic [3:0] CMD_RD  = 4'h5;

    // address bits with extra meaning
    localparam int AP_BIT = 10;
    localparam int BC_BIT = 12;

    // mode register selection by bank address and op-code fields
    localparam logic [BANK_W-1:0] MR0_SEL = 3'h0;
    localparam logic [BANK_W-1:0] MR1_SEL = 3'h1;
    localparam int BL_LSB    = 0;
    localparam int BT_BIT    = 3;
    localparam int CL_LSB    = 4;
    localparam int CL_HI_BIT = 2;
    localparam int AL_LSB    = 3;

    // burst length codes
    localparam logic [1:0] BL_FIXED8 = 2'h0;
    localparam logic [1:0] BL_OTF    = 2'h1;
    localparam logic [1:0] BL_FIXED4 = 2'h2;

    // posted command delay codes
    localparam logic [1:0] AL_ZERO = 2'h0;
    localparam logic [1:0] AL_CLM1 = 2'h1;
    localparam logic [1:0] AL_CLM2 = 2'h2;

    // read latency arithmetic and reset value
    localparam logic [CL_W-1:0] CL_BASE    = 5'h4;
    localparam logic [CL_W-1:0] CL_HI_STEP = 5'h8;
    localparam logic [CL_W-1:0] CL_RESET   = 5'h5;
    localparam logic [CL_W-1:0] AL_OFF1    = 5'h1;
    localparam logic [CL_W-1:0] AL_OFF2    = 5'h2;

    // last beat index for chopped and full bursts
    localparam logic [2:0] LAST_BEAT4 = 3'h3;
    localparam logic [2:0] LAST_BEAT8 = 3'h7;

    typedef enum logic [2:0] {
        KIND_ACT,
        KIND_PRE,
        KIND_MRS,
        KIND_REF
    } dca_kind_t;

    typedef enum logic [1:0] {
        PWR_ACTIVE,
        PWR_PDOWN,
        PWR_SREF,
        PWR_SUSPEND
    } dca_pwr_t;

    // one sample of every link-side input pin
    typedef struct packed {
        logic              ck;
        logic              ck_n;
        logic              cke;
        logic              cs_n;
        logic              ras_n;
        logic              cas_n;
        logic              we_n;
        logic [BANK_W-1:0] ba;
        logic [ROW_W-1:0]  addr;
    } dca_pins_t;

endpackage
